// *** hdl/wwd_pkg.sv ***
package wwd_pkg;

  // core clock and low-power oscillator rates
  localparam int unsigned CORE_CLK_KHZ = 10000;
  localparam int unsigned OSC_KHZ = 32;
  localparam int unsigned OSC_DIV = CORE_CLK_KHZ / OSC_KHZ;

  // prescaler divides
  localparam logic [7:0] PRE5_DIV = 8'h20;
  localparam logic [7:0] PRE7_DIV = 8'h80;

  // nominal base timeout at 1:1 postscale
  localparam int unsigned BASE_TIMEOUT5_US = 1000;
  localparam int unsigned BASE_TIMEOUT7_US = 4000;

  // wdt_config_word field positions
  localparam int unsigned CFG_POST_LSB = 0;
  localparam int unsigned CFG_POST_W = 4;
  localparam int unsigned CFG_PRE_BIT = 4;
  localparam int unsigned CFG_WINOFF_BIT = 6;
  localparam int unsigned CFG_HWEN_BIT = 7;

  // reset_control_reg field positions
  localparam int unsigned RCR_IDLE_BIT = 2;
  localparam int unsigned RCR_SLEEP_BIT = 3;
  localparam int unsigned RCR_TOFLAG_BIT = 4;
  localparam int unsigned RCR_SWEN_BIT = 5;
  localparam int unsigned RCR_W = 8;

  // reset values
  localparam logic RST_SWEN = 1'b0;
  localparam logic RST_FLAG = 1'b0;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_IDLE = 2'b10
  } wwd_mode_t;

endpackage

// *** hdl/wwd_tick_div.sv ***
`timescale 1ns/1ns
module wwd_tick_div #(
  parameter int unsigned DIV = wwd_pkg::OSC_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick_r
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;

  // oscillator stops when the watchdog is off
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (cnt_r == LAST);
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

endmodule // wwd_tick_div

// *** hdl/wwd_top.sv ***
`timescale 1ns/1ns
// Function
// R1: counter runs on low-power oscillator ticks
// R2: prescaler divides by 32 or 128
// R3: base period 1 ms or 4 ms
// R4: postscaler ratio 1:1 to 1:32768
// R5: device reset clears all counts
// R6: clock switch completion clears all counts
// R7: power-save entry clears all counts
// R8: power-save exit clears all counts
// R9: clear instruction clears all counts
// R10: keeps counting in sleep and idle
// R11: timeout in power-save wakes, not resets
// R12: sleep/idle status stays until software clears
// R13: hardware enable forces watchdog on
// R14: otherwise software enable bit controls it
// R15: software enable cleared by reset
// R16: early clear in window mode resets device
// R17: timeout flag sticky until software clears
// R18: run-mode timeout resets device, sets flag
module wwd_top #(
  parameter int unsigned OSC_DIV = wwd_pkg::OSC_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] wdt_config_word,
  input wire logic rcr_wr,
  input wire logic [7:0] rcr_wdata,
  input wire logic clear_watchdog_instr,
  input wire logic power_save_sleep,
  input wire logic power_save_idle,
  input wire logic other_wake,
  input wire logic clk_switch_done,
  output logic [7:0] reset_control_reg,
  output logic osc_enable_r,
  output logic wdt_reset_r,
  output logic wake_r,
  output logic window_open_r
);

  logic hw_wdt_enable;
  logic prescale_select;
  logic window_disable;
  logic [3:0] postscale_select;
  logic sw_wdt_enable_r;
  logic timeout_flag_r;
  logic sleep_stat_r;
  logic idle_stat_r;
  logic wdt_on;
  logic tick_r;
  logic [6:0] pre_cnt_r;
  logic [14:0] post_cnt_r;
  logic pre_wrap;
  logic timeout;
  logic clr_cmd;
  logic early_clr;
  logic in_window;
  logic ps_entry;
  logic ps_exit;
  logic clr_all;
  wwd_pkg::wwd_mode_t mode_r;
  wwd_pkg::wwd_mode_t mode_nxt;

  function automatic logic [15:0] post_ratio(input logic [3:0] sel);
    post_ratio = 16'h0001 << sel;
  endfunction

  function automatic logic [7:0] pre_div(input logic sel);
    pre_div = sel ? wwd_pkg::PRE7_DIV : wwd_pkg::PRE5_DIV;
  endfunction

  assign hw_wdt_enable = wdt_config_word[wwd_pkg::CFG_HWEN_BIT];
  assign prescale_select = wdt_config_word[wwd_pkg::CFG_PRE_BIT];
  assign window_disable = wdt_config_word[wwd_pkg::CFG_WINOFF_BIT];
  assign postscale_select =
    wdt_config_word[wwd_pkg::CFG_POST_LSB +: wwd_pkg::CFG_POST_W];

  assign wdt_on = hw_wdt_enable | sw_wdt_enable_r; // [R13] [R14]

  wwd_tick_div #(
    .DIV(OSC_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(wdt_on), // [R1]
    .tick_r(tick_r)
  );

  // compare with >= so a ratio lowered mid-count ends at the next wrap
  assign pre_wrap = tick_r &&
    ({1'b0, pre_cnt_r} >= pre_div(prescale_select) - 8'h01); // [R2]
  // a clear in the wrap cycle beats the timeout
  assign timeout = wdt_on && pre_wrap && !clr_cmd && // [R3] [R4]
    ({1'b0, post_cnt_r} >= post_ratio(postscale_select) - 16'h0001);

  // elapsed and total in oscillator ticks; last quarter is 4*e >= 3*t
  always_comb
  begin
    logic [24:0] elapsed;
    logic [24:0] total;
    elapsed = 25'(post_cnt_r) * 25'(pre_div(prescale_select))
      + 25'(pre_cnt_r);
    total = 25'(post_ratio(postscale_select))
      * 25'(pre_div(prescale_select));
    in_window = ((elapsed << 2) >= (total * 25'h3));
  end

  // clear instruction only counts in normal execution
  assign clr_cmd = clear_watchdog_instr && (mode_r == wwd_pkg::MODE_RUN);
  assign early_clr = clr_cmd && wdt_on && !window_disable
    && !in_window; // [R16]
  assign ps_entry = (mode_r == wwd_pkg::MODE_RUN)
    && (power_save_sleep || power_save_idle);
  assign ps_exit = (mode_r != wwd_pkg::MODE_RUN)
    && (other_wake || timeout);
  assign clr_all = !wdt_on || clr_cmd || ps_entry || ps_exit
    || clk_switch_done || timeout; // [R6] [R7] [R8] [R9]

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_r <= '0; // [R5]
      post_cnt_r <= '0; // [R5]
    end
    else if (clr_all)
    begin
      pre_cnt_r <= '0;
      post_cnt_r <= '0;
    end
    else if (pre_wrap)
    begin
      // counting goes on whatever the power mode
      pre_cnt_r <= '0; // [R10]
      post_cnt_r <= post_cnt_r + 15'h0001;
    end
    else if (tick_r)
    begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      wwd_pkg::MODE_RUN:
      begin
        if (power_save_sleep)
          mode_nxt = wwd_pkg::MODE_SLEEP;
        else if (power_save_idle)
          mode_nxt = wwd_pkg::MODE_IDLE;
      end
      wwd_pkg::MODE_SLEEP,
      wwd_pkg::MODE_IDLE:
      begin
        if (ps_exit)
          mode_nxt = wwd_pkg::MODE_RUN;
      end
      default:
        mode_nxt = wwd_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= wwd_pkg::MODE_RUN;
    else
      mode_r <= mode_nxt;
  end

  // timeout in power-save wakes; in run mode it resets
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_reset_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      wdt_reset_r <= (timeout && (mode_r == wwd_pkg::MODE_RUN))
        || early_clr; // [R18] [R16]
      wake_r <= timeout && (mode_r != wwd_pkg::MODE_RUN); // [R11]
    end
  end

  // software enable; lost on every device reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_wdt_enable_r <= wwd_pkg::RST_SWEN; // [R15]
    else if (rcr_wr)
      sw_wdt_enable_r <= rcr_wdata[wwd_pkg::RCR_SWEN_BIT]; // [R14]
  end

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      timeout_flag_r <= wwd_pkg::RST_FLAG;
    else if ((timeout && (mode_r == wwd_pkg::MODE_RUN)) || early_clr)
      timeout_flag_r <= 1'b1; // [R18] [R17]
    else if (rcr_wr)
      timeout_flag_r <= rcr_wdata[wwd_pkg::RCR_TOFLAG_BIT]; // [R17]
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_stat_r <= wwd_pkg::RST_FLAG;
      idle_stat_r <= wwd_pkg::RST_FLAG;
    end
    else
    begin
      // status survives the wake; only software drops it
      if (ps_entry && power_save_sleep)
        sleep_stat_r <= 1'b1; // [R12]
      else if (rcr_wr)
        sleep_stat_r <= rcr_wdata[wwd_pkg::RCR_SLEEP_BIT]; // [R12]
      if (ps_entry && !power_save_sleep)
        idle_stat_r <= 1'b1; // [R12]
      else if (rcr_wr)
        idle_stat_r <= rcr_wdata[wwd_pkg::RCR_IDLE_BIT]; // [R12]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_enable_r <= 1'b0;
      window_open_r <= 1'b0;
    end
    else
    begin
      osc_enable_r <= wdt_on; // [R1]
      window_open_r <= wdt_on && (window_disable || in_window);
    end
  end

  always_comb
  begin
    reset_control_reg = 8'h00;
    reset_control_reg[wwd_pkg::RCR_SWEN_BIT] = sw_wdt_enable_r;
    reset_control_reg[wwd_pkg::RCR_TOFLAG_BIT] = timeout_flag_r;
    reset_control_reg[wwd_pkg::RCR_SLEEP_BIT] = sleep_stat_r;
    reset_control_reg[wwd_pkg::RCR_IDLE_BIT] = idle_stat_r;
  end

endmodule // wwd_top

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  localparam int DIV = 2;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] cfg = 8'hC0;
  logic rcr_wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic csw = 1'b0;
  logic clr, slp, idl, owk, en, wrst, wake, wopen;
  logic [7:0] rcr;
  int fails = 0;
  int n_compared = 0;
  always #50 core_clk = ~core_clk;
  wwd_cpu_model i_cpu (.core_clk(core_clk), .clr(clr), .slp(slp),
    .idl(idl), .owk(owk));
  wwd_top #(.OSC_DIV(DIV)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .wdt_config_word(cfg), .rcr_wr(rcr_wr), .rcr_wdata(wd),
    .clear_watchdog_instr(clr), .power_save_sleep(slp),
    .power_save_idle(idl), .other_wake(owk), .clk_switch_done(csw),
    .reset_control_reg(rcr), .osc_enable_r(en), .wdt_reset_r(wrst),
    .wake_r(wake), .window_open_r(wopen));
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // bounded wait on reset pulse, window or wake
  task automatic wt(int k, output int n);
    n = 0;
    while ((k == 0 ? wrst : k == 1 ? wopen : wake) !== 1'b1 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    if (n >= 2000)
      fails++;
  endtask
  task automatic wr(logic [7:0] v);
    rcr_wr = 1'b1;
    wd = v;
    cyc(1);
    rcr_wr = 1'b0;
  endtask
  task automatic t_period;
    int n;
    logic ok;
    logic [7:0] c [3] = '{8'hC0, 8'hD0, 8'hC2};
    int e [3] = '{32, 128, 128};
    for (int i = 0; i < 3; i++)
    begin
      cfg = c[i];
      wr(8'h00);
      wt(0, n);
      cyc(1);
      chk("flag", rcr[4], 1'b1);
      wt(0, n);
      ok = n >= e[i] * DIV - 1 && n <= e[i] * DIV + 1;
      chk("period", ok, 1'b1);
      cyc(1);
    end
  endtask
  task automatic t_window;
    int n;
    cfg = 8'h80;
    wt(0, n);
    cyc(8);
    i_cpu.op(0);
    chk("early", wrst, 1'b1);
    wt(1, n);
    i_cpu.op(0);
    chk("late", wrst, 1'b0);
    wt(0, n);
    chk("cleared", n >= 60, 1'b1);
  endtask
  task automatic t_sleep;
    int n;
    cfg = 8'hC0;
    for (int k = 1; k <= 2; k++)
    begin
      wt(0, n);
      cyc(4);
      i_cpu.op(k);
      chk("stat", rcr[3:2], k == 1 ? 2'b10 : 2'b01);
      wt(2, n);
      chk("wake", n >= 60 && n < 2000, 1'b1);
      cyc(1);
      chk("keep", rcr[3:2] != 2'b00, 1'b1);
      wr(8'h00);
      cyc(20);
      i_cpu.op(k);
      cyc(20);
      i_cpu.op(3);
      wt(0, n);
      chk("exit", n >= 60, 1'b1);
      wr(8'h00);
    end
  endtask
  task automatic t_sw;
    int n;
    cfg = 8'h40;
    cyc(3);
    chk("off", en, 1'b0);
    wr(8'h20);
    cyc(2);
    chk("on", en, 1'b1);
    wt(0, n);
    cyc(40);
    csw = 1'b1;
    cyc(1);
    csw = 1'b0;
    wt(0, n);
    chk("switch", n >= 60, 1'b1);
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    chk("rst", {rcr, en}, 9'h000);
  endtask
  task automatic end_of_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    cyc(3);
    rst_n = 1'b1;
    chk("init", {rcr, en}, 9'h000);
    t_period;
    t_window;
    t_sleep;
    t_sw;
    end_of_test;
  end
  initial
  begin
    #3000000;
    fails++;
    end_of_test;
  end
endmodule // tb_top
bind wwd_top wwd_top_chk #(.OSC_DIV(OSC_DIV)) i_chk (.core_clk(core_clk),
  .rst_n(rst_n), .wdt_config_word(wdt_config_word), .rcr_wr(rcr_wr),
  .clear_watchdog_instr(clear_watchdog_instr),
  .reset_control_reg(reset_control_reg), .osc_enable_r(osc_enable_r),
  .wdt_reset_r(wdt_reset_r), .wake_r(wake_r), .window_open_r(window_open_r));

// *** tb/wwd_cpu_model.sv ***
`timescale 1ns/1ns
module wwd_cpu_model (
  output logic clr,
  output logic slp,
  output logic idl,
  output logic owk,
  input wire logic core_clk
);
  initial {clr, slp, idl, owk} = 4'h0;
  // one-cycle instruction strobe
  task automatic op(input int k);
    @(posedge core_clk);
    #1;
    case (k)
      0: clr = 1'b1;
      1: slp = 1'b1;
      2: idl = 1'b1;
      default: owk = 1'b1;
    endcase
    @(posedge core_clk);
    #1;
    {clr, slp, idl, owk} = 4'h0;
  endtask
endmodule // wwd_cpu_model

// *** tb/wwd_top_assertions.sv ***
`timescale 1ns/1ns
module wwd_top_chk #(
  parameter int unsigned OSC_DIV = wwd_pkg::OSC_DIV
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] wdt_config_word,
  input wire logic rcr_wr,
  input wire logic clear_watchdog_instr,
  input wire logic [7:0] reset_control_reg,
  input wire logic osc_enable_r,
  input wire logic wdt_reset_r,
  input wire logic wake_r,
  input wire logic window_open_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic hw = wdt_config_word[7];
  wire logic run = reset_control_reg[3:2] == 2'b00;
  property p_hw; hw |=> osc_enable_r; endproperty
  a_hw: assert property (p_hw) else $error("hw enable ignored");
  property p_sw; !hw && !reset_control_reg[5] |=> !osc_enable_r; endproperty
  a_sw: assert property (p_sw) else $error("sw enable ignored");
  property p_off;
    !osc_enable_r && !$past(osc_enable_r) |-> !wake_r && !wdt_reset_r;
  endproperty
  a_off: assert property (p_off) else $error("event while off");
  property p_pulse; wdt_reset_r |=> !wdt_reset_r; endproperty
  a_pulse: assert property (p_pulse) else $error("reset too long");
  property p_wake;
    wake_r |-> !wdt_reset_r && !run;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_flag;
    reset_control_reg[4] && !rcr_wr |=> reset_control_reg[4];
  endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
  property p_early;
    clear_watchdog_instr && !wdt_config_word[6] && run
      ##1 !window_open_r && osc_enable_r |-> wdt_reset_r
      && reset_control_reg[4];
  endproperty
  a_early: assert property (p_early) else $error("early clear");
  property p_late;
    clear_watchdog_instr && run ##1 window_open_r |-> !wdt_reset_r;
  endproperty
  a_late: assert property (p_late) else $error("late clear");
  c_rst: cover property (wdt_reset_r);
  c_wake: cover property (wake_r);
  c_clr: cover property (clear_watchdog_instr && window_open_r);
endmodule // wwd_top_chk
